// >>> design/thermal_monitor_regs.vh
// Function
// - One remote result step is one eighth degree; span -128 to 127.875 degrees.
// - Remote high byte holds whole degrees as two's complement; local result stores measurement bits 6..0, bit 7 zero.
// - Remote low byte holds three fraction bits in bits 7..5, rest zero.
// - Measured remote values below zero are clamped to zero.
// - Both channels compared against high and low limits after each sample.
// - Separate read and write addresses; crossing them gives invalid data.
// - First written byte loads the pointer; it selects later access.
// - Result registers written only by conversion engine; bus read-only.
// - Offset is 11-bit two's complement: high at 0x11, low at 0x12.
// - Offset negative when bit 7 of offset high byte is one.
// - Offset added to each remote sample; resets to zero.
// - Offset accepts -128 to +127.875 degrees in eighth steps.
// - Offset sum saturates at positive or negative extreme.
// - Results read at 00, 01, 10; high bytes reset 0x80, low byte zero.
// - Local high limit read 05, written 0B, resets 0x7F.
// - Local low limit read 06, written 0C, resets 0xC9.
// - Remote high limit: read 07, write 0D, reset 0x7F; low at 13.
// - Remote low limit: read 08, write 0E, reset 0xC9; low at 14.
// - Writing 0F triggers one measurement; data discarded, no storage.
// - A one-shot from standby converts once, then returns to standby.
`ifndef THERMAL_MONITOR_REGS_VH
`define THERMAL_MONITOR_REGS_VH
`define RD_LOCAL_RESULT     8'h00
`define RD_REMOTE_RES_HI    8'h01
`define RD_ALARM_FLAGS      8'h02
`define RD_DEVICE_SETUP     8'h03
`define RD_SAMPLE_RATE      8'h04
`define RD_LOCAL_UPPER      8'h05
`define RD_LOCAL_LOWER      8'h06
`define RD_REMOTE_UPPER_HI  8'h07
`define RD_REMOTE_LOWER_HI  8'h08
`define RD_REMOTE_RES_LO    8'h10
`define RD_RSVD_A           8'h19
`define RD_MAKER_ID         8'hfe
`define RD_SILICON_REV      8'hff
`define WR_DEVICE_SETUP     8'h09
`define WR_SAMPLE_RATE      8'h0a
`define WR_LOCAL_UPPER      8'h0b
`define WR_LOCAL_LOWER      8'h0c
`define WR_REMOTE_UPPER_HI  8'h0d
`define WR_REMOTE_LOWER_HI  8'h0e
`define WR_SINGLE_MEASURE   8'h0f
`define RW_OFFSET_HI        8'h11
`define RW_OFFSET_LO        8'h12
`define RW_REMOTE_UPPER_LO  8'h13
`define RW_REMOTE_LOWER_LO  8'h14
`define RST_RESULT_HI       8'h80
`define RST_RESULT_LO       8'h00
`define RST_SETUP           8'h00
`define RST_RATE            8'h02
`define RST_UPPER           8'h7f
`define RST_LOWER           8'hc9
`define RST_OFFSET          8'h00
`define RST_LIMIT_LO        8'h00
`define SETUP_MASK_BIT      7
`define SETUP_STANDBY_BIT   6
`define FLAG_BUSY_BIT       7
`define FLAG_LHIGH_BIT      6
`define FLAG_LLOW_BIT       5
`define FLAG_RHIGH_BIT      4
`define FLAG_RLOW_BIT       3
`define FLAG_OPEN_BIT       2
`define FRAC_LSB            5
`define RESULT_MAX          11'h3ff
`define SUM_POS_MAX         11'h3ff
`define SUM_NEG_MIN         11'h400
`endif

// >>> design/thermal_monitor.v
`timescale 1ns/1ps
`include "thermal_monitor_regs.vh"
module thermal_monitor #(
  parameter [7:0] MAKER_ID_VALUE = 8'h5a, // Arbitrary value
  parameter [7:0] SILICON_REV    = 8'h01  // Arbitrary value
) (
  input  wire        mclk_i,
  input  wire        rst_b_i,
  input  wire        wr_ptr_i,
  input  wire        wr_data_i,
  input  wire        rd_data_i,
  input  wire [7:0]  bus_wdata_i,
  output reg  [7:0]  bus_rdata_o,
  input  wire        sample_tick_i,
  input  wire        conv_done_i,
  input  wire [7:0]  local_meas_i,
  input  wire [10:0] remote_meas_i,
  input  wire        remote_neg_i,
  input  wire        remote_open_i,
  input  wire        standby_pin_b_i,
  output wire        conv_start_o,
  output wire        standby_o,
  output wire        alert_mask_o,
  output wire [7:0]  rate_code_o,
  output wire        conv_busy_o,
  output wire [4:0]  limit_trip_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [7:0]  ptr_q;
  reg  [7:0]  local_res_q;
  reg  [7:0]  remote_hi_q;
  reg  [7:0]  remote_lo_q;
  reg  [7:0]  setup_q;
  reg  [7:0]  rate_q;
  reg  [7:0]  local_upper_q;
  reg  [7:0]  local_lower_q;
  reg  [7:0]  remote_upper_hi_q;
  reg  [7:0]  remote_lower_hi_q;
  reg  [7:0]  offset_hi_q;
  reg  [7:0]  offset_lo_q;
  reg  [7:0]  remote_upper_lo_q;
  reg  [7:0]  remote_lower_lo_q;
  reg  [4:0]  trip_q;
  reg         busy_q;
  reg         one_shot_q;
  reg         stby_meta_q;
  reg         stby_sync_q;

  wire        one_shot_wr;
  wire        standby;
  wire [11:0] off_ext;
  wire [11:0] meas_ext;
  wire [11:0] sum;
  reg  [10:0] remote_sat;
  wire [10:0] remote_res;
  wire [10:0] remote_upper;
  wire [10:0] remote_lower;
  reg  [7:0]  rdata_d;

  // Limits are signed bytes; results share the same signed compare
  function gt_signed;
    input [10:0] a;
    input [10:0] b;
    begin
      gt_signed = $signed(a) > $signed(b);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Standby pin synchroniser

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      stby_meta_q <= 1'b1;
      stby_sync_q <= 1'b1;
    end
    else
    begin
      stby_meta_q <= standby_pin_b_i;
      stby_sync_q <= stby_meta_q;
    end
  end

  assign standby = setup_q[`SETUP_STANDBY_BIT] | ~stby_sync_q;
  // A pointer byte takes priority, so it must not also fire the one-shot
  assign one_shot_wr = wr_data_i && !wr_ptr_i &&
                       (ptr_q == `WR_SINGLE_MEASURE);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion control

  // A conversion starts on a rate tick while running, or once per one-shot
  // in standby or running; the one-shot request is consumed by the start.
  assign conv_start_o = ~busy_q &
                        ((~standby & sample_tick_i) | one_shot_q);
  assign conv_busy_o  = busy_q;
  assign standby_o    = standby;
  assign alert_mask_o = setup_q[`SETUP_MASK_BIT];
  assign rate_code_o  = rate_q;
  assign limit_trip_o = trip_q;

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      busy_q     <= 1'b0;
      one_shot_q <= 1'b0;
    end
    else
    begin
      if (conv_start_o)
        busy_q <= 1'b1;
      else if (conv_done_i)
        busy_q <= 1'b0;
      // New request wins over consumption in the same cycle
      if (one_shot_wr)
        one_shot_q <= 1'b1;
      else if (conv_start_o)
        one_shot_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote offset path

  assign off_ext  = {offset_hi_q[7], offset_hi_q,
                     offset_lo_q[7:`FRAC_LSB]};
  // Sub-zero measurements clamp to zero before the offset
  assign meas_ext = remote_neg_i ? 12'h000 : {1'b0, remote_meas_i};
  assign sum      = meas_ext + off_ext;

  always @*
  begin
    remote_sat = sum[10:0];
    if (!sum[11] && sum[10])
      remote_sat = `SUM_POS_MAX;
    else if (sum[11] && !sum[10])
      remote_sat = `SUM_NEG_MIN;
    else
      remote_sat = sum[10:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparison

  assign remote_res   = {remote_hi_q, remote_lo_q[7:`FRAC_LSB]};
  assign remote_upper = {remote_upper_hi_q, remote_upper_lo_q[7:`FRAC_LSB]};
  assign remote_lower = {remote_lower_hi_q, remote_lower_lo_q[7:`FRAC_LSB]};

  ////////////////////////////////////////////////////////////////////////////
  // Result and trip registers

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      local_res_q <= `RST_RESULT_HI;
      remote_hi_q <= `RST_RESULT_HI;
      remote_lo_q <= `RST_RESULT_LO;
      trip_q      <= 5'h00;
    end
    else if (conv_done_i && busy_q)
    begin
      // Only the conversion engine writes results
      local_res_q <= {1'b0, local_meas_i[6:0]};
      remote_hi_q <= remote_sat[10:3];
      remote_lo_q <= {remote_sat[2:0], 5'h00};
    end
    else
    begin
      // Compare runs the cycle after storing so stored values are used
      trip_q[4] <= gt_signed({local_res_q, 3'h0},
                             {local_upper_q, 3'h0});
      trip_q[3] <= gt_signed({local_lower_q, 3'h0},
                             {local_res_q, 3'h0});
      trip_q[2] <= gt_signed(remote_res, remote_upper);
      trip_q[1] <= gt_signed(remote_lower, remote_res);
      trip_q[0] <= remote_open_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and writable registers

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      ptr_q             <= 8'h00;
      setup_q           <= `RST_SETUP;
      rate_q            <= `RST_RATE;
      local_upper_q     <= `RST_UPPER;
      local_lower_q     <= `RST_LOWER;
      remote_upper_hi_q <= `RST_UPPER;
      remote_lower_hi_q <= `RST_LOWER;
      offset_hi_q       <= `RST_OFFSET;
      offset_lo_q       <= `RST_OFFSET;
      remote_upper_lo_q <= `RST_LIMIT_LO;
      remote_lower_lo_q <= `RST_LIMIT_LO;
    end
    else if (wr_ptr_i)
      ptr_q <= bus_wdata_i;
    else if (wr_data_i)
    begin
      // Read addresses are not decoded here, so crossed writes are dropped
      case (ptr_q)
        `WR_DEVICE_SETUP:    setup_q <= bus_wdata_i;
        `WR_SAMPLE_RATE:     rate_q <= bus_wdata_i;
        `WR_LOCAL_UPPER:     local_upper_q <= bus_wdata_i;
        `WR_LOCAL_LOWER:     local_lower_q <= bus_wdata_i;
        `WR_REMOTE_UPPER_HI: remote_upper_hi_q <= bus_wdata_i;
        `WR_REMOTE_LOWER_HI: remote_lower_hi_q <= bus_wdata_i;
        `RW_OFFSET_HI:       offset_hi_q <= bus_wdata_i;
        `RW_OFFSET_LO:       offset_lo_q <= {bus_wdata_i[7:5], 5'h00};
        `RW_REMOTE_UPPER_LO: remote_upper_lo_q <= {bus_wdata_i[7:5], 5'h00};
        `RW_REMOTE_LOWER_LO: remote_lower_lo_q <= {bus_wdata_i[7:5], 5'h00};
        default:             ptr_q <= ptr_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  always @*
  begin
    rdata_d = 8'h00;
    case (ptr_q)
      `RD_LOCAL_RESULT:    rdata_d = local_res_q;
      `RD_REMOTE_RES_HI:   rdata_d = remote_hi_q;
      `RD_ALARM_FLAGS:     rdata_d = {busy_q, trip_q, 2'b00};
      `RD_DEVICE_SETUP:    rdata_d = setup_q;
      `RD_SAMPLE_RATE:     rdata_d = rate_q;
      `RD_LOCAL_UPPER:     rdata_d = local_upper_q;
      `RD_LOCAL_LOWER:     rdata_d = local_lower_q;
      `RD_REMOTE_UPPER_HI: rdata_d = remote_upper_hi_q;
      `RD_REMOTE_LOWER_HI: rdata_d = remote_lower_hi_q;
      `RD_REMOTE_RES_LO:   rdata_d = remote_lo_q;
      `RW_OFFSET_HI:       rdata_d = offset_hi_q;
      `RW_OFFSET_LO:       rdata_d = offset_lo_q;
      `RW_REMOTE_UPPER_LO: rdata_d = remote_upper_lo_q;
      `RW_REMOTE_LOWER_LO: rdata_d = remote_lower_lo_q;
      `RD_RSVD_A:          rdata_d = 8'h00;
      `RD_MAKER_ID:        rdata_d = MAKER_ID_VALUE;
      `RD_SILICON_REV:     rdata_d = SILICON_REV;
      default:             rdata_d = 8'h00;
    endcase
  end

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
      bus_rdata_o <= 8'h00;
    else if (rd_data_i)
      bus_rdata_o <= rdata_d;
  end

endmodule // thermal_monitor

// >>> bench/smbus_host_model.sv
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic [7:0] rdata_i,
  input  wire logic       mclk_i,
  output logic            wr_ptr_o,
  output logic            wr_data_o,
  output logic            rd_data_o,
  output logic [7:0]      wdata_o
);
  initial {wr_ptr_o, wr_data_o, rd_data_o, wdata_o} = 11'h000;
  task automatic drive(input logic [2:0] s, input logic [7:0] v);
    @(posedge mclk_i);
    #1;
    {wr_ptr_o, wr_data_o, rd_data_o} = s;
    wdata_o = v;
  endtask
  // Released data lines flip so a stale byte never looks valid
  task automatic put(input logic [7:0] ptr, input logic [7:0] d);
    drive(3'b100, ptr);
    drive(3'b010, d);
    drive(3'b000, ~d);
  endtask
  task automatic get(input logic [7:0] ptr, output logic [7:0] q);
    drive(3'b100, ptr);
    drive(3'b001, ~ptr);
    drive(3'b000, ptr);
    q = rdata_i;
  endtask
endmodule // smbus_host_model

// >>> bench/thermal_monitor_checker.sv
`timescale 1ns/1ps
module thermal_monitor_checker (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        wr_ptr_i,
  input wire logic        wr_data_i,
  input wire logic        rd_data_i,
  input wire logic [7:0]  bus_wdata_i,
  input wire logic [7:0]  bus_rdata_o,
  input wire logic        conv_done_i,
  input wire logic        conv_start_o,
  input wire logic        alert_mask_o,
  input wire logic [7:0]  rate_code_o,
  input wire logic        conv_busy_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_one_shot;
    wr_ptr_i && bus_wdata_i == 8'h0f ##1
      wr_data_i && !wr_ptr_i && !conv_busy_o && !conv_start_o;
  endsequence
  chk_start_busy: assert property (conv_start_o |=> conv_busy_o)
    else $error("busy did not follow start");
  chk_busy_cause: assert property ($rose(conv_busy_o) |-> $past(conv_start_o))
    else $error("busy rose without start");
  chk_one_shot: assert property (s_one_shot |=> conv_start_o)
    else $error("single measure write gave no start");
  chk_busy_no_start: assert property (conv_busy_o |-> !conv_start_o)
    else $error("start while busy");
  chk_done_idle: assert property (conv_busy_o && conv_done_i |=> !conv_busy_o)
    else $error("busy held after done");
  chk_busy_holds: assert property (conv_busy_o && !conv_done_i |=> conv_busy_o)
    else $error("busy dropped early");
  chk_rdata_hold: assert property (!$past(rd_data_i) |-> $stable(bus_rdata_o))
    else $error("read data moved without read");
  chk_mask_source: assert property ($changed(alert_mask_o) |-> $past(wr_data_i))
    else $error("mask changed without write");
  chk_rate_source: assert property ($changed(rate_code_o) |-> $past(wr_data_i))
    else $error("rate changed without write");
endmodule // thermal_monitor_checker
bind thermal_monitor thermal_monitor_checker u_thermal_monitor_checker (
  .mclk_i, .rst_b_i, .wr_ptr_i, .wr_data_i, .rd_data_i, .bus_wdata_i,
  .bus_rdata_o, .conv_done_i, .conv_start_o, .alert_mask_o, .rate_code_o,
  .conv_busy_o);

// >>> bench/test_thermal_monitor.sv
`timescale 1ns/1ps
module test_thermal_monitor;
  logic        mclk_i = 0, rst_b_i = 0, sample_tick_i = 0, conv_done_i = 0;
  logic        remote_neg_i = 0, remote_open_i = 0, standby_pin_b_i = 1;
  logic [7:0]  local_meas_i = 8'h00;
  logic [10:0] remote_meas_i = 11'h000;
  logic        wr_ptr_i, wr_data_i, rd_data_i, conv_start_o, standby_o;
  logic        alert_mask_o, conv_busy_o;
  logic [7:0]  bus_wdata_i, bus_rdata_o, rate_code_o, rd;
  logic [4:0]  limit_trip_o;
  int          miscompares = 0, n_compared = 0;
  always #5 mclk_i = ~mclk_i;
  // Identity values are arbitrary
  thermal_monitor #(.MAKER_ID_VALUE(8'h3c), .SILICON_REV(8'h07)) u_thermal_monitor (
    .mclk_i, .rst_b_i, .wr_ptr_i, .wr_data_i, .rd_data_i, .bus_wdata_i,
    .bus_rdata_o, .sample_tick_i, .conv_done_i, .local_meas_i, .remote_meas_i,
    .remote_neg_i, .remote_open_i, .standby_pin_b_i, .conv_start_o, .standby_o,
    .alert_mask_o, .rate_code_o, .conv_busy_o, .limit_trip_o);
  smbus_host_model u_smbus_host_model (.mclk_i, .rdata_i(bus_rdata_o),
    .wr_ptr_o(wr_ptr_i), .wr_data_o(wr_data_i), .rd_data_o(rd_data_i),
    .wdata_o(bus_wdata_i));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [10:0] exp, logic [10:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    logic [7:0] a [16] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h15, 8'hfe};
    logic [7:0] e [16] = '{8'h80, 8'h80, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f,
      8'hc9, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3c};
    for (int i = 0; i < 16; i++)
    begin
      u_smbus_host_model.get(a[i], rd);
      check("reset value", e[i], rd);
    end
    // Power-up results sit below both lower limits
    check("trips", 5'b01010, limit_trip_o);
    $display("test_reset done");
  endtask
  task automatic test_regs;
    logic [7:0] w [10] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11, 8'h12, 8'h13,
      8'h14, 8'h0a, 8'h09};
    logic [7:0] r [10] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h11, 8'h12, 8'h13,
      8'h14, 8'h04, 8'h03};
    logic [7:0] v [10] = '{8'h50, 8'he0, 8'h64, 8'hc0, 8'hfc, 8'he0, 8'hbf,
      8'h60, 8'h07, 8'hc0};
    logic [7:0] e [10] = '{8'h50, 8'he0, 8'h64, 8'hc0, 8'hfc, 8'he0, 8'ha0,
      8'h60, 8'h07, 8'hc0};
    for (int i = 0; i < 10; i++)
    begin
      u_smbus_host_model.put(w[i], v[i]);
      u_smbus_host_model.get(r[i], rd);
      check("register", e[i], rd);
    end
    check("standby", 1'b1, standby_o);
    check("mask", 1'b1, alert_mask_o);
    check("rate", 8'h07, rate_code_o);
    u_smbus_host_model.put(8'h05, 8'h00);
    u_smbus_host_model.get(8'h05, rd);
    check("crossed write", 8'h50, rd);
    u_smbus_host_model.put(8'h00, 8'h11);
    u_smbus_host_model.get(8'h00, rd);
    check("result write", 8'h80, rd);
    $display("test_regs done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic run_case(logic [7:0] lm, logic [10:0] rm, logic neg,
    logic [7:0] oh, logic [7:0] ol, logic [7:0] el, logic [7:0] eh,
    logic [7:0] elo);
    int n;
    u_smbus_host_model.put(8'h11, oh);
    u_smbus_host_model.put(8'h12, ol);
    u_smbus_host_model.put(8'h0f, 8'ha5);
    for (n = 0; n < 20 && conv_start_o !== 1'b1; n++) @(posedge mclk_i) #1;
    if (n == 20)
    begin
      miscompares++;
      summarize;
    end
    repeat (3) @(posedge mclk_i);
    #1;
    {local_meas_i, remote_meas_i, remote_neg_i, conv_done_i} = {lm, rm, neg, 1'b1};
    @(posedge mclk_i);
    #1;
    {remote_meas_i, conv_done_i, sample_tick_i} = {~rm, 1'b0, 1'b1};
    // In standby the rate ticks must not restart conversion
    for (n = 0; n < 3; n++)
    begin
      @(posedge mclk_i) #1;
      check("no restart", 1'b0, conv_start_o | conv_busy_o);
    end
    sample_tick_i = 0;
    u_smbus_host_model.get(8'h00, rd);
    check("local result", el, rd);
    u_smbus_host_model.get(8'h01, rd);
    check("remote high", eh, rd);
    u_smbus_host_model.get(8'h10, rd);
    check("remote low", elo, rd);
  endtask
  task automatic test_convert;
    run_case(8'h19, 11'h090, 0, 8'hfc, 8'h00, 8'h19, 8'h0e, 8'h00);
    run_case(8'h7f, 11'h090, 0, 8'h00, 8'h20, 8'h7f, 8'h12, 8'h20);
    // Local 127 is above the local upper limit of 80 written earlier
    check("trips local", 5'b10000, limit_trip_o);
    u_smbus_host_model.get(8'h02, rd);
    check("alarm flags", 8'h40, rd);
    run_case(8'h00, 11'h3f8, 0, 8'h7f, 8'he0, 8'h00, 8'h7f, 8'he0);
    // Saturated remote result is above the remote upper limit
    check("trips remote", 5'b00100, limit_trip_o);
    run_case(8'h01, 11'h000, 0, 8'h80, 8'h00, 8'h01, 8'h80, 8'h00);
    run_case(8'h02, 11'h123, 1, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00);
    run_case(8'h03, 11'h3ff, 0, 8'h00, 8'h00, 8'h03, 8'h7f, 8'he0);
    $display("test_convert done");
  endtask
  initial
  begin
    repeat (5) @(posedge mclk_i);
    #1 rst_b_i = 1;
    test_reset;
    test_regs;
    test_convert;
    summarize;
  end
endmodule // test_thermal_monitor
